/* File: design/wwdr_pkg.sv */
// Constants and types of the windowed watchdog register block.
package wwdr_pkg;
    localparam int ADDR_W = 5;
    localparam int CNT_W = 24;
    localparam logic [4:0] OFS_MODE = 5'h00;
    localparam logic [4:0] OFS_RELOAD = 5'h04;
    localparam logic [4:0] OFS_FEED = 5'h08;
    localparam logic [4:0] OFS_COUNT = 5'h0C;
    localparam logic [4:0] OFS_CLOCK_SOURCE_SELECT = 5'h10;
    localparam logic [4:0] OFS_WARN = 5'h14;
    localparam logic [4:0] OFS_WINDOW = 5'h18;
    localparam int BIT_RUN = 0;
    localparam int BIT_CHIPRST = 1;
    localparam int BIT_TOF = 2;
    localparam int BIT_WARN = 3;
    localparam int BIT_GUARD = 4;
    localparam int BIT_LOCK = 5;
    localparam int BIT_SEL_LOCK = 31;
    localparam logic [23:0] RST_RELOAD = 24'h0000FF;
    localparam logic [23:0] RST_COUNT = 24'h0000FF;
    localparam logic [23:0] RST_WARNCMP = 24'h000000;
    localparam logic [23:0] RST_WINDOW = 24'hFFFFFF;
    localparam logic [5:0] RST_MODE = 6'h00;
    localparam logic [7:0] FEED_FIRST = 8'hAA;
    localparam logic [7:0] FEED_SECOND = 8'h55;
    localparam logic [1:0] PRE_LAST = 2'h3;
    localparam logic [2:0] PM_ACTIVE = 3'h0;
    localparam logic [2:0] PM_SLEEP = 3'h1;
    localparam logic [2:0] PM_DEEP_SLEEP = 3'h2;
    localparam logic [2:0] PM_POWER_DOWN = 3'h3;
    localparam logic [2:0] PM_DEEP_PD = 3'h4;
    typedef enum logic {WWDR_FEED_IDLE, WWDR_FEED_ARMED} wwdr_feed_e;
endpackage : wwdr_pkg

/* File: design/wwdr_top.sv */
// Windowed watchdog register block with counter, feed and mode control.
module wwdr_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [wwdr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wdclk,
    input wire logic [2:0] power_mode,
    input wire logic core_irq_en,
    input wire logic wakeup_start_en,
    output logic chip_reset,
    output logic warn_irq,
    output logic wake_req,
    output logic clk_lock,
    output logic clk_select
);
    import wwdr_pkg::*;

    logic wdclk_s1_ff, wdclk_s2_ff, wdclk_s3_ff;
    logic [5:0] sh_ff, nxt_sh, eff_ff, nxt_eff;
    logic tof_ff, nxt_tof, wint_ff, nxt_wint;
    logic [23:0] reload_ff, nxt_reload, cnt_ff, nxt_cnt;
    logic [23:0] warn_ff, nxt_warn, win_ff, nxt_win;
    logic sel_ff, nxt_sel, sel_lock_ff, nxt_sel_lock;
    wwdr_feed_e feed_ff, nxt_feed;
    logic [1:0] pre_ff, nxt_pre;
    logic chip_reset_ff, nxt_chip_reset;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic irq_ff, nxt_irq, wake_ff, nxt_wake;
    logic acc, wr, tick, feed_ok, feed_err, early, guard_bad, wd_event;
    logic [23:0] wval;

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign chip_reset = chip_reset_ff;
    assign warn_irq = irq_ff;
    assign wake_req = wake_ff;
    assign clk_lock = eff_ff[BIT_LOCK];
    assign clk_select = sel_ff;

    // The watchdog clock is foreign, so only its synchronised copy is used.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wdclk_s1_ff <= 1'b0;
            wdclk_s2_ff <= 1'b0;
            wdclk_s3_ff <= 1'b0;
        end else begin
            wdclk_s1_ff <= wdclk;
            wdclk_s2_ff <= wdclk_s1_ff;
            wdclk_s3_ff <= wdclk_s2_ff;
        end
    end

    always_comb begin
        acc = psel & penable & ~pready_ff;
        wr = acc & pwrite;
        wval = (pwdata[23:0] < RST_RELOAD) ? RST_RELOAD : pwdata[23:0];
        nxt_sh = sh_ff;
        nxt_eff = eff_ff;
        nxt_tof = tof_ff;
        nxt_wint = wint_ff;
        nxt_reload = reload_ff;
        nxt_cnt = cnt_ff;
        nxt_warn = warn_ff;
        nxt_win = win_ff;
        nxt_sel = sel_ff;
        nxt_sel_lock = sel_lock_ff;
        nxt_feed = feed_ff;
        nxt_pre = pre_ff;
        nxt_pready = acc;
        nxt_prdata = 32'h00000000;
        nxt_pslverr = 1'b0;
        feed_ok = 1'b0;
        feed_err = 1'b0;
        early = 1'b0;
        guard_bad = 1'b0;
        tick = 1'b0;
        // Counting stops in deep power-down, where nothing is clocked.
        if (eff_ff[BIT_RUN] && wdclk_s2_ff && !wdclk_s3_ff
                && power_mode != PM_DEEP_PD) begin
            nxt_pre = pre_ff + 2'h1;
            tick = (pre_ff == PRE_LAST);
        end
        if (tick) begin
            nxt_cnt = (cnt_ff == 24'h000000) ? reload_ff : cnt_ff - 24'h000001;
        end
        // Feed sequence tracking; the access after the first byte decides.
        case (feed_ff)
            WWDR_FEED_IDLE: begin
                if (wr && paddr == OFS_FEED && pwdata[7:0] == FEED_FIRST) begin
                    nxt_feed = WWDR_FEED_ARMED;
                end
            end
            WWDR_FEED_ARMED: begin
                if (acc) begin
                    nxt_feed = WWDR_FEED_IDLE;
                    feed_ok = wr && paddr == OFS_FEED
                        && pwdata[7:0] == FEED_SECOND;
                    feed_err = !feed_ok && eff_ff[BIT_RUN];
                end
            end
            default: nxt_feed = WWDR_FEED_IDLE;
        endcase
        if (feed_ok) begin
            nxt_cnt = reload_ff;
            nxt_pre = 2'h0;
            nxt_eff = sh_ff;
            early = eff_ff[BIT_RUN] && cnt_ff > win_ff;
        end
        if (acc) begin
            case (paddr)
                OFS_MODE: nxt_prdata = {26'h0, sh_ff[BIT_LOCK],
                    sh_ff[BIT_GUARD], wint_ff, tof_ff, sh_ff[1:0]};
                OFS_RELOAD: nxt_prdata = {8'h00, reload_ff};
                OFS_FEED: nxt_prdata = 32'h00000000;
                OFS_COUNT: nxt_prdata = {8'h00, cnt_ff};
                OFS_CLOCK_SOURCE_SELECT: nxt_prdata = {sel_lock_ff, 30'h0, sel_ff};
                OFS_WARN: nxt_prdata = {8'h00, warn_ff};
                OFS_WINDOW: nxt_prdata = {8'h00, win_ff};
                default: nxt_pslverr = 1'b1;
            endcase
        end
        if (wr) begin
            case (paddr)
                OFS_MODE: begin
                    // Bits 31:6 are dropped; software should write zero.
                    nxt_sh[BIT_RUN] = sh_ff[BIT_RUN] | pwdata[BIT_RUN];
                    nxt_sh[BIT_CHIPRST] = sh_ff[BIT_CHIPRST]
                        | pwdata[BIT_CHIPRST];
                    nxt_sh[BIT_GUARD] = sh_ff[BIT_GUARD]
                        | pwdata[BIT_GUARD];
                    nxt_sh[BIT_LOCK] = sh_ff[BIT_LOCK] | pwdata[BIT_LOCK];
                    if (!pwdata[BIT_TOF]) begin
                        nxt_tof = 1'b0;
                    end
                    if (pwdata[BIT_WARN]) begin
                        nxt_wint = 1'b0;
                    end
                end
                OFS_RELOAD: begin
                    if (eff_ff[BIT_GUARD]
                            && !(cnt_ff < warn_ff && cnt_ff < win_ff)) begin
                        guard_bad = 1'b1;
                    end else begin
                        nxt_reload = wval;
                    end
                end
                OFS_CLOCK_SOURCE_SELECT: begin
                    if (!sel_lock_ff) begin
                        nxt_sel = pwdata[0];
                    end
                    nxt_sel_lock = sel_lock_ff | pwdata[BIT_SEL_LOCK];
                end
                OFS_WARN: nxt_warn = pwdata[23:0];
                OFS_WINDOW: nxt_win = pwdata[23:0];
                default: ;
            endcase
        end
        // Hardware sets come last so a same-cycle software clear loses.
        if (tick && cnt_ff != 24'h000000
                && cnt_ff - 24'h000001 == warn_ff) begin
            nxt_wint = 1'b1;
        end
        wd_event = (tick && cnt_ff == 24'h000001) || feed_err
            || early || guard_bad;
        if (wd_event) begin
            nxt_tof = 1'b1;
        end
        nxt_chip_reset = wd_event && eff_ff[BIT_CHIPRST];
        // The pulse acts as the watchdog's own reset one cycle later.
        if (chip_reset_ff) begin
            nxt_sh = RST_MODE;
            nxt_eff = RST_MODE;
            // A flag clear written during the pulse must not hide the cause.
            nxt_tof = tof_ff;
            nxt_wint = 1'b0;
            nxt_reload = RST_RELOAD;
            nxt_cnt = RST_COUNT;
            nxt_warn = RST_WARNCMP;
            nxt_win = RST_WINDOW;
            nxt_sel = 1'b0;
            nxt_sel_lock = 1'b0;
            nxt_feed = WWDR_FEED_IDLE;
            nxt_pre = 2'h0;
            nxt_chip_reset = 1'b0;
        end
        nxt_irq = nxt_wint && power_mode != PM_DEEP_PD;
        nxt_wake = nxt_wint && core_irq_en && (power_mode == PM_SLEEP
            || ((power_mode == PM_DEEP_SLEEP
            || power_mode == PM_POWER_DOWN) && wakeup_start_en));
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sh_ff <= RST_MODE;
            eff_ff <= RST_MODE;
            tof_ff <= 1'b0;
            wint_ff <= 1'b0;
            reload_ff <= RST_RELOAD;
            cnt_ff <= RST_COUNT;
            warn_ff <= RST_WARNCMP;
            win_ff <= RST_WINDOW;
            sel_ff <= 1'b0;
            sel_lock_ff <= 1'b0;
            feed_ff <= WWDR_FEED_IDLE;
            pre_ff <= 2'h0;
            chip_reset_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            irq_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            sh_ff <= nxt_sh;
            eff_ff <= nxt_eff;
            tof_ff <= nxt_tof;
            wint_ff <= nxt_wint;
            reload_ff <= nxt_reload;
            cnt_ff <= nxt_cnt;
            warn_ff <= nxt_warn;
            win_ff <= nxt_win;
            sel_ff <= nxt_sel;
            sel_lock_ff <= nxt_sel_lock;
            feed_ff <= nxt_feed;
            pre_ff <= nxt_pre;
            chip_reset_ff <= nxt_chip_reset;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            irq_ff <= nxt_irq;
            wake_ff <= nxt_wake;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_run_sticky: assert property (
        sh_ff[BIT_RUN] && !chip_reset_ff |=> sh_ff[BIT_RUN])
        else $error("Run bit cleared without reset.");
    a_chiprst_sticky: assert property (
        sh_ff[BIT_CHIPRST] && !chip_reset_ff |=> sh_ff[BIT_CHIPRST])
        else $error("Chip reset enable cleared without reset.");
    a_timeout_flag: assert property (
        tick && cnt_ff == 24'h000001 && eff_ff[BIT_CHIPRST]
        |=> tof_ff && chip_reset_ff ##1 tof_ff && cnt_ff == RST_COUNT)
        else $error("Time-out did not flag and reset.");
    a_tof_survives: assert property (
        chip_reset_ff && tof_ff |=> tof_ff && sh_ff == RST_MODE)
        else $error("Time-out flag lost on own reset.");
    a_guard_reject: assert property (
        wr && paddr == OFS_RELOAD && eff_ff[BIT_GUARD]
        && cnt_ff >= warn_ff && !chip_reset_ff
        |=> tof_ff && $stable(reload_ff))
        else $error("Early guarded reload accepted.");
    a_mode_defer: assert property (
        !feed_ok && !chip_reset_ff |=> $stable(eff_ff))
        else $error("Mode changed without feed.");
    a_feed_load: assert property (
        feed_ok && !chip_reset_ff |=> cnt_ff == $past(reload_ff)
        && eff_ff == $past(sh_ff))
        else $error("Feed did not reload counter.");
    a_reload_floor: assert property (
        reload_ff >= RST_RELOAD)
        else $error("Reload constant below floor.");
    a_feed_error: assert property (
        feed_ff == WWDR_FEED_ARMED && acc && !feed_ok && eff_ff[BIT_RUN]
        && eff_ff[BIT_CHIPRST] && !chip_reset_ff |=> chip_reset_ff && tof_ff)
        else $error("Feed error not reset.");
    a_prescale: assert property (
        tick |-> pre_ff == PRE_LAST && eff_ff[BIT_RUN])
        else $error("Counter stepped off prescale.");
    a_lock_sticky: assert property (
        eff_ff[BIT_LOCK] && !chip_reset_ff |=> eff_ff[BIT_LOCK])
        else $error("Clock lock cleared without reset.");
    a_guard_sticky: assert property (
        sh_ff[BIT_GUARD] && !chip_reset_ff |=> sh_ff[BIT_GUARD])
        else $error("Reload guard cleared without reset.");
    a_warn_set: assert property (
        tick && warn_ff != 24'hFFFFFF && cnt_ff == warn_ff + 24'h000001
        && !chip_reset_ff |=> wint_ff)
        else $error("Warning flag not set at compare.");
    a_early_feed: assert property (
        feed_ok && eff_ff[BIT_RUN] && cnt_ff > win_ff && !chip_reset_ff
        |=> tof_ff)
        else $error("Early feed not flagged.");
    a_deep_pd_quiet: assert property (
        power_mode == PM_DEEP_PD |=> !irq_ff)
        else $error("Warning output raised in deep power-down.");
    a_wake_deep: assert property (
        (power_mode == PM_DEEP_SLEEP || power_mode == PM_POWER_DOWN)
        && !wakeup_start_en |=> !wake_ff)
        else $error("Wake request without start enable.");
endmodule : wwdr_top

/* File: bench/wwdr_cpu_model.sv */
// Processor-side register bus model for the watchdog register block.
module wwdr_cpu_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [wwdr_pkg::ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    import wwdr_pkg::*;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 5'h00;
        pwdata = 32'h00000000;
    end

    // The request is held until pready is sampled high or eight cycles pass, then released.
    task automatic xfer(input logic wr, input logic [4:0] a,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic ok);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        rd = prdata;
        ok = (pready === 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle data is scrambled so that a stale value cannot pass.
        pwdata <= ~d;
    endtask : xfer

    // Reserved mode bits are always sent as zero.
    task automatic write_mode(input logic [5:0] bits, output logic ok);
        logic [31:0] rd;
        xfer(1'b1, OFS_MODE, {26'h0000000, bits}, rd, ok);
    endtask : write_mode

    // The two feed writes go out as consecutive accesses.
    task automatic feed(output logic ok);
        logic [31:0] rd;
        logic ok1;
        xfer(1'b1, OFS_FEED, {24'h000000, FEED_FIRST}, rd, ok1);
        xfer(1'b1, OFS_FEED, {24'h000000, FEED_SECOND}, rd, ok);
        ok = ok & ok1;
    endtask : feed
endmodule : wwdr_cpu_model

/* File: bench/wwdr_tb_top.sv */
// Self-checking testbench of the watchdog register block.
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    miscompares++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module wwdr_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import wwdr_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wdclk = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [4:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] power_mode = PM_ACTIVE;
    logic core_irq_en = 1'b0;
    logic wakeup_start_en = 1'b0;
    logic chip_reset, warn_irq, wake_req, clk_lock, clk_select;
    int miscompares = 0;
    int n_compared = 0;
    int n_rst = 0;
    int n_slverr = 0;

    always #25 clk = ~clk;
    // The watchdog clock runs free, four system clocks per phase.
    always #200 wdclk = ~wdclk;
    always @(posedge clk) if (chip_reset === 1'b1) n_rst++;
    always @(posedge clk) if (pready === 1'b1 && pslverr === 1'b1) n_slverr++;

    wwdr_top u_wwdr_top (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wdclk(wdclk), .power_mode(power_mode),
        .core_irq_en(core_irq_en), .wakeup_start_en(wakeup_start_en),
        .chip_reset(chip_reset), .warn_irq(warn_irq), .wake_req(wake_req),
        .clk_lock(clk_lock), .clk_select(clk_select));
    wwdr_cpu_model u_wwdr_cpu_model (.clk(clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    task automatic finish_test;
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic hung(input logic ok);
        if (ok !== 1'b1) begin
            miscompares++;
            $display("ERROR wait ran out of its bound");
            finish_test();
        end
    endtask : hung

    task automatic rd_chk(input string nm, input logic [4:0] a,
                          input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic ok;
        u_wwdr_cpu_model.xfer(1'b0, a, 32'h00000000, d, ok);
        hung(ok);
        `CHK(nm, e & m, d & m)
    endtask : rd_chk

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic ok;
        u_wwdr_cpu_model.xfer(1'b1, a, d, rd, ok);
        hung(ok);
    endtask : wr

    task automatic mode(input logic [5:0] bits);
        logic ok;
        u_wwdr_cpu_model.write_mode(bits, ok);
        hung(ok);
    endtask : mode

    task automatic do_feed;
        logic ok;
        u_wwdr_cpu_model.feed(ok);
        hung(ok);
    endtask : do_feed

    // Waits on the warning output (sel 0) or the chip reset pulse.
    task automatic wait_sig(input int sel, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((sel == 0 ? warn_irq : chip_reset) !== 1'b1 && n < lim);
        hung(n < lim);
    endtask : wait_sig

    task automatic reset_values;
        rd_chk("mode", OFS_MODE, 32'h0000003F, 32'h00000000);
        rd_chk("reload", OFS_RELOAD, 32'h00FFFFFF, 32'h000000FF);
        rd_chk("count", OFS_COUNT, 32'h00FFFFFF, 32'h000000FF);
        rd_chk("window", OFS_WINDOW, 32'h00FFFFFF, 32'h00FFFFFF);
        wr(OFS_RELOAD, 32'h00001234);
        rd_chk("reload rw", OFS_RELOAD, 32'h00FFFFFF, 32'h00001234);
        wr(OFS_RELOAD, 32'h00000010);
        rd_chk("reload min", OFS_RELOAD, 32'h00FFFFFF, 32'h000000FF);
    endtask : reset_values

    task automatic guard_and_feed_error;
        logic [31:0] d;
        logic ok;
        mode(6'h31);
        `CHK("lock before feed", 1'b0, clk_lock)
        do_feed();
        // The counter sits near 0xFF, above the zero warning compare.
        wr(OFS_RELOAD, 32'h00001000);
        rd_chk("guarded reload", OFS_RELOAD, 32'h00FFFFFF, 32'h000000FF);
        rd_chk("guard event", OFS_MODE, 32'h00000004, 32'h00000004);
        `CHK("lock after feed", 1'b1, clk_lock)
        mode(6'h20);
        do_feed();
        rd_chk("set once", OFS_MODE, 32'h00000015, 32'h00000011);
        wr(OFS_FEED, {24'h000000, FEED_FIRST});
        u_wwdr_cpu_model.xfer(1'b0, OFS_RELOAD, 32'h00000000, d, ok);
        hung(ok);
        rd_chk("feed error", OFS_MODE, 32'h00000004, 32'h00000004);
        `CHK("no chip reset", 0, n_rst)
        mode(6'h30);
    endtask : guard_and_feed_error

    task automatic timeout_reset;
        wr(OFS_WARN, 32'h00000080);
        mode(6'h02);
        do_feed();
        wait_sig(0, 20000);
        `CHK("warning", 1'b1, warn_irq)
        power_mode <= PM_SLEEP;
        core_irq_en <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("wake sleep", 1'b1, wake_req)
        power_mode <= PM_DEEP_SLEEP;
        repeat (3) @(posedge clk);
        `CHK("wake deep", 1'b0, wake_req)
        power_mode <= PM_ACTIVE;
        wait_sig(1, 20000);
        repeat (3) @(posedge clk);
        `CHK("reset pulses", 1, n_rst)
        rd_chk("after reset", OFS_MODE, 32'h0000003F, 32'h00000004);
        `CHK("lock cleared", 1'b0, clk_lock)
        `CHK("warn cleared", 1'b0, warn_irq)
        rd_chk("count reset", OFS_COUNT, 32'h00FFFFFF, 32'h000000FF);
        mode(6'h00);
        do_feed();
        rd_chk("flag clear", OFS_MODE, 32'h00000004, 32'h00000000);
    endtask : timeout_reset

    // The wdclk period of eight clocks makes one tick every 32 clocks.
    task automatic window_select_rate;
        logic [31:0] d1, d2;
        logic ok;
        wr(OFS_CLOCK_SOURCE_SELECT, 32'h80000001);
        wr(OFS_CLOCK_SOURCE_SELECT, 32'h00000000);
        `CHK("select locked", 1'b1, clk_select)
        rd_chk("clock_source_select", OFS_CLOCK_SOURCE_SELECT, 32'h80000001, 32'h80000001);
        wr(OFS_COUNT, 32'h00000000);
        rd_chk("count ro", OFS_COUNT, 32'h00FFFFFF, 32'h000000FF);
        u_wwdr_cpu_model.xfer(1'b0, 5'h1C, 32'h00000000, d1, ok);
        hung(ok);
        @(posedge clk);
        `CHK("bus errors", 1, n_slverr)
        wr(OFS_WARN, 32'h000000E0);
        mode(6'h01);
        do_feed();
        u_wwdr_cpu_model.xfer(1'b0, OFS_COUNT, 32'h00000000, d1, ok);
        hung(ok);
        repeat (316) @(posedge clk);
        u_wwdr_cpu_model.xfer(1'b0, OFS_COUNT, 32'h00000000, d2, ok);
        hung(ok);
        `CHK("count rate", 24'h00000A, d1[23:0] - d2[23:0])
        wait_sig(0, 2000);
        power_mode <= PM_DEEP_PD;
        repeat (2) @(posedge clk);
        `CHK("deep pd quiet", 1'b0, warn_irq)
        power_mode <= PM_ACTIVE;
        repeat (2) @(posedge clk);
        `CHK("warn back", 1'b1, warn_irq)
        mode(6'h09);
        `CHK("warn clear", 1'b0, warn_irq)
        wr(OFS_WINDOW, 32'h00000080);
        rd_chk("window rw", OFS_WINDOW, 32'h00FFFFFF, 32'h00000080);
        do_feed();
        rd_chk("early feed", OFS_MODE, 32'h00000004, 32'h00000004);
        `CHK("no reset", 1, n_rst)
    endtask : window_select_rate

    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        reset_values();
        guard_and_feed_error();
        timeout_reset();
        window_select_rate();
        finish_test();
    end
endmodule : wwdr_tb_top
